// *** bench/lpsm_host_model.sv ***
// host side model: builds register frames and collects the answers
`timescale 1ns/1ps
module lpsm_host_model (
  // clock
  input  wire logic                  sys_clk,
  // frame to device
  output      logic                  frame_valid,
  output      lpsm_pkg::lpsm_frame_t frame_data,
  // answer from device
  input  wire logic                  readback_valid,
  input  wire logic [15:0]           readback_data
);
  import lpsm_pkg::*;

  initial begin
    frame_valid = 1'h0;
    frame_data  = 16'h0000;
  end

  // ***********************************************
  // frame building
  // ***********************************************
  // reserved positions always sent as zero, keeps room for future functions
  function automatic logic [15:0] clean(input logic [15:0] w);
    case (w[15:14])
      LPSM_SEL_LIN_CTRL: clean = w & 16'hF01D;
      LPSM_SEL_SPECIAL:  clean = w & 16'hF278;
      default:           clean = w;
    endcase
  endfunction : clean

  // one frame, one cycle of valid; idle data is inverted so no stale word lingers
  task automatic send_frame(input logic [15:0] w, output logic got, output logic [15:0] ans);
    @(negedge sys_clk);
    frame_valid = 1'h1;
    frame_data  = clean(w);
    @(negedge sys_clk);
    frame_valid = 1'h0;
    frame_data  = ~frame_data;
    got         = readback_valid;
    ans         = readback_data;
  endtask : send_frame

endmodule : lpsm_host_model

// *** bench/testbench.sv ***
// self-checking bench for the LIN control and special mode registers
`timescale 1ns/1ps
module testbench;
  import lpsm_pkg::*;

  logic        sys_clk, rst_b, frame_valid, readback_valid, mode_normal_or_flash;
  lpsm_frame_t frame_data;
  logic [15:0] gp1_feedback, int_en_feedback, readback_data;
  logic        lin_if_fail, lin_comm_ok, lin_active_enable, lin_slope_select;
  logic        lin_drive_strength, lin_tx_disable, lin_tx_enable, sw_dev_mode_init;
  logic [1:0]  watchdog_prescale_sel, supply_reset_threshold_sel;
  logic [3:0]  prescale_half_units;
  logic [6:0]  reset_threshold_pct;
  logic [3:0]  lin_sh;
  logic [4:0]  sp_sh;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;

  lpsm_regs lpsm_regs_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .frame_valid(frame_valid), .frame_data(frame_data),
    .gp1_feedback(gp1_feedback), .int_en_feedback(int_en_feedback),
    .readback_valid(readback_valid), .readback_data(readback_data),
    .mode_normal_or_flash(mode_normal_or_flash), .lin_if_fail(lin_if_fail),
    .lin_comm_ok(lin_comm_ok), .lin_active_enable(lin_active_enable),
    .lin_slope_select(lin_slope_select), .lin_drive_strength(lin_drive_strength),
    .lin_tx_disable(lin_tx_disable), .lin_tx_enable(lin_tx_enable),
    .sw_dev_mode_init(sw_dev_mode_init), .watchdog_prescale_sel(watchdog_prescale_sel),
    .supply_reset_threshold_sel(supply_reset_threshold_sel),
    .prescale_half_units(prescale_half_units), .reset_threshold_pct(reset_threshold_pct)
  );

  lpsm_host_model lpsm_host_model_inst (
    .sys_clk(sys_clk), .frame_valid(frame_valid), .frame_data(frame_data),
    .readback_valid(readback_valid), .readback_data(readback_data)
  );

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ***********************************************
  // checking and closing
  // ***********************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // ceiling far above the roughly 120 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("ERROR at %0t: run did not complete", $time);
      print_verdict();
    end
  end

  task automatic check_outs();
    logic [3:0] pre;
    logic [6:0] thr;
    case (sp_sh[3:2])
      2'h0:    pre = LPSM_PRE_X1_0;
      2'h1:    pre = LPSM_PRE_X1_5;
      2'h2:    pre = LPSM_PRE_X2_5;
      default: pre = LPSM_PRE_X3_5;
    endcase
    case (sp_sh[1:0])
      2'h1:    thr = LPSM_THR_PCT_80;
      2'h2:    thr = LPSM_THR_PCT_70;
      default: thr = LPSM_THR_PCT_90;
    endcase
    check(16'(lin_active_enable), 16'(lin_sh[3] & mode_normal_or_flash), "active");
    check(16'(lin_slope_select), 16'(lin_sh[2]), "slope");
    check(16'(lin_drive_strength), 16'(lin_sh[1]), "drive");
    check(16'(lin_tx_disable), 16'(lin_sh[0]), "tx disable");
    check(16'(sw_dev_mode_init), 16'(sp_sh[4]), "dev mode");
    check(16'(watchdog_prescale_sel), 16'(sp_sh[3:2]), "prescale sel");
    check(16'(prescale_half_units), 16'(pre), "prescale");
    check(16'(supply_reset_threshold_sel), 16'(sp_sh[1:0]), "threshold sel");
    check(16'(reset_threshold_pct), 16'(thr), "threshold");
  endtask : check_outs

  task automatic check_reset();
    lin_sh = 4'h0;
    sp_sh  = 5'h00;
    check_outs();
    check(16'(lin_tx_enable), 16'h0000, "tx enable in reset");
    check(16'(readback_valid), 16'h0000, "strobe in reset");
    check(readback_data, 16'h0000, "answer in reset");
  endtask : check_reset

  // one frame: expected answer from pre-write shadow, then shadow update
  task automatic access(input logic [15:0] w);
    logic        got;
    logic [15:0] ans;
    logic [15:0] want;
    want = 16'h0000;
    if (w[15:14] == LPSM_SEL_LIN_CTRL) begin
      want = w[13] ? gp1_feedback : {w[15:12], 7'h00, lin_sh[3:1], 1'h0, lin_sh[0]};
    end else if (w[15:14] == LPSM_SEL_SPECIAL) begin
      want = w[13] ? {w[15:12], 2'h0, sp_sh[4], 2'h0, sp_sh[3:0], 3'h0} : int_en_feedback;
    end
    lpsm_host_model_inst.send_frame(w, got, ans);
    check(16'(got), 16'h0001, "answer strobe");
    check(ans, want, "answer word");
    if (!w[12] && w[15:14] == LPSM_SEL_LIN_CTRL) lin_sh = {w[4], w[3], w[2], w[0]};
    if (!w[12] && w[15:14] == LPSM_SEL_SPECIAL) sp_sh = {w[9], w[6:3]};
    check_outs();
  endtask : access

  task automatic pulse(input logic fail, input logic ok);
    @(negedge sys_clk);
    lin_if_fail = fail;
    lin_comm_ok = ok;
    @(negedge sys_clk);
    lin_if_fail = 1'h0;
    lin_comm_ok = 1'h0;
    @(negedge sys_clk);
  endtask : pulse

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    rst_b = 1'h0;
    mode_normal_or_flash = 1'h0;
    lin_if_fail = 1'h0;
    lin_comm_ok = 1'h0;
    gp1_feedback = 16'hA5C3;
    int_en_feedback = 16'h3C5A;
    repeat (6) @(negedge sys_clk);
    check_reset();
    rst_b = 1'h1;
    @(negedge sys_clk);
    check(16'(lin_tx_enable), 16'h0001, "tx enable after reset");
    // start-up programming, every prescale and threshold code
    for (int i = 0; i < 4; i++) begin
      access({4'h6, 2'h3, 1'(i), 2'h3, 2'(i), 2'(3 - i), 3'h7});
    end
    access(16'h7278);
    access(16'h5278);
    for (int m = 0; m < 2; m++) begin
      mode_normal_or_flash = 1'(m);
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < 16; i++) begin
        access({4'hE, 7'h7F, 1'(i >> 3), 1'(i >> 2), 1'(i >> 1), 1'h1, 1'(i)});
      end
    end
    access(16'hF01D);
    access(16'hE01D);
    access(16'h001D);
    access(16'h801D);
    // tx shutdown, automatic and manual recovery
    access(16'hC000);
    pulse(1'h1, 1'h0);
    check(16'(lin_tx_enable), 16'h0000, "tx after failure");
    check(16'(lin_tx_disable), 16'h0000, "disable bit after failure");
    pulse(1'h1, 1'h1);
    check(16'(lin_tx_enable), 16'h0000, "failure beats recovery");
    pulse(1'h0, 1'h1);
    check(16'(lin_tx_enable), 16'h0001, "auto recovery");
    pulse(1'h1, 1'h0);
    access(16'hC001);
    check(16'(lin_tx_enable), 16'h0000, "tx while disabled");
    access(16'hC000);
    @(negedge sys_clk);
    check(16'(lin_tx_enable), 16'h0001, "manual recovery");
    // second reset in mid-run
    rst_b = 1'h0;
    @(negedge sys_clk);
    check_reset();
    rst_b = 1'h1;
    access(16'hE01C);
    print_verdict();
  end

endmodule : testbench

// *** hw/lpsm_frame_decode.sv ***
// header decode of one received 16-bit register frame
`timescale 1ns/1ps
module lpsm_frame_decode (
  // frame in
  input  wire logic                 frame_valid,
  input  wire lpsm_pkg::lpsm_frame_t frame_data,
  // decoded
  output      lpsm_pkg::lpsm_decode_t dec
);
  import lpsm_pkg::*;

  always_comb begin
    dec          = '0;
    dec.hit_lin  = frame_valid && (frame_data.register_select_bits == LPSM_SEL_LIN_CTRL); // [R1] [R20]
    dec.hit_spec = frame_valid && (frame_data.register_select_bits == LPSM_SEL_SPECIAL);  // [R12] [R20]
    dec.wr_lin   = dec.hit_lin && !frame_data.no_write_flag;                              // [R3]
    dec.wr_spec  = dec.hit_spec && !frame_data.no_write_flag;                             // [R14]
    dec.alt_sel  = frame_data.readback_select;
  end

endmodule : lpsm_frame_decode

// *** hw/lpsm_pkg.sv ***
// constants, frame layout and field types for the LIN control / special mode registers
package lpsm_pkg;

  // ***********************************************
  // frame header: register select codes
  // ***********************************************
  localparam logic [1:0] LPSM_SEL_LIN_CTRL = 2'h3;
  localparam logic [1:0] LPSM_SEL_SPECIAL  = 2'h1;

  // ***********************************************
  // payload field positions
  // ***********************************************
  localparam int LPSM_LIN_ACT_BIT   = 4;
  localparam int LPSM_LIN_SLOPE_BIT = 3;
  localparam int LPSM_LIN_DRIVE_BIT = 2;
  localparam int LPSM_LIN_TXDIS_BIT = 0;
  localparam int LPSM_SPEC_SW_DEV_MODE_INIT_BIT = 9;
  localparam int LPSM_SPEC_WDP_LSB  = 5;
  localparam int LPSM_SPEC_THR_LSB  = 3;

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [3:0] LPSM_LIN_CTRL_RST = 4'h0;
  localparam logic [4:0] LPSM_SPECIAL_RST  = 5'h00;

  // ***********************************************
  // decoded settings
  // ***********************************************
  localparam logic [3:0] LPSM_PRE_X1_0 = 4'h2;
  localparam logic [3:0] LPSM_PRE_X1_5 = 4'h3;
  localparam logic [3:0] LPSM_PRE_X2_5 = 4'h5;
  localparam logic [3:0] LPSM_PRE_X3_5 = 4'h7;
  localparam logic [6:0] LPSM_THR_PCT_90 = 7'h5A;
  localparam logic [6:0] LPSM_THR_PCT_80 = 7'h50;
  localparam logic [6:0] LPSM_THR_PCT_70 = 7'h46;

  // ***********************************************
  // types
  // ***********************************************
  typedef struct packed {
    logic [1:0]  register_select_bits;
    logic        readback_select;
    logic        no_write_flag;
    logic [11:0] payload;
  } lpsm_frame_t;

  typedef struct packed {
    logic lin_active_enable;
    logic lin_slope_select;
    logic lin_drive_strength;
    logic lin_tx_disable;
  } lpsm_lin_ctrl_t;

  typedef struct packed {
    logic       sw_dev_mode_init;
    logic [1:0] watchdog_prescale_sel;
    logic [1:0] supply_reset_threshold_sel;
  } lpsm_special_t;

  typedef struct packed {
    logic hit_lin;
    logic hit_spec;
    logic wr_lin;
    logic wr_spec;
    logic alt_sel;
  } lpsm_decode_t;

  typedef enum logic [1:0] {
    LPSM_TX_NORMAL   = 2'h0,
    LPSM_TX_FAIL_OFF = 2'h1,
    LPSM_TX_ARMED    = 2'h3
  } lpsm_tx_state_t;

endpackage : lpsm_pkg

// *** hw/lpsm_regs.sv ***
// LIN transceiver control and special mode registers with feedback and tx shutdown recovery
`timescale 1ns/1ps
// Behaviour
// [R1] select bits 15:14 equal to 11 address the LIN control register
// [R2] LIN access returns GP feedback 1 when bit 13 set, else LIN feedback
// [R3] bit 12 clear returns feedback and writes; set only returns feedback
// [R4] host writes zero into LIN control bits 11 to 5 and bit 1
// [R5] bit 4 enables LIN active operation only in Normal or Flash mode
// [R6] bit 3 picks low slope (1) or normal slope (0)
// [R7] bit 2 picks increased driver current (1) or standard driver (0)
// [R8] bit 0 set disables the LIN transmitter, clear enables it
// [R9] interface failure disables transmitter without setting the disable bit
// [R10] correct LIN communication after failure re-enables transmitter automatically
// [R11] setting then clearing the disable bit also clears a failure shutdown
// [R12] select bits 15:14 equal to 01 address the special mode register
// [R13] special access returns interrupt enable feedback at 0, own feedback at 1
// [R14] special mode write only when bit 12 is clear
// [R15] software programs special mode settings during start-up
// [R16] bit 9 set initialises software development mode
// [R17] bits 6:5 pick watchdog prescale factor 1, 1.5, 2.5 or 3.5
// [R18] bits 4:3 pick reset threshold 0.9, 0.8, 0.7 or 0.9 of nominal
// [R19] host keeps special mode reserved bits 11,10,8,7,2:0 at zero
// [R20] header bits decoded before payload is applied or discarded
module lpsm_regs (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // register frame
  input  wire logic                  frame_valid,
  input  wire lpsm_pkg::lpsm_frame_t frame_data,
  input  wire logic [15:0]           gp1_feedback,
  input  wire logic [15:0]           int_en_feedback,
  output      logic                  readback_valid,
  output      logic [15:0]           readback_data,
  // chip state
  input  wire logic                  mode_normal_or_flash,
  // LIN interface monitor
  input  wire logic                  lin_if_fail,
  input  wire logic                  lin_comm_ok,
  // LIN transceiver controls
  output      logic                  lin_active_enable,
  output      logic                  lin_slope_select,
  output      logic                  lin_drive_strength,
  output      logic                  lin_tx_disable,
  output      logic                  lin_tx_enable,
  // global settings
  output      logic                  sw_dev_mode_init,
  output      logic [1:0]            watchdog_prescale_sel,
  output      logic [1:0]            supply_reset_threshold_sel,
  output      logic [3:0]            prescale_half_units,
  output      logic [6:0]            reset_threshold_pct
);
  import lpsm_pkg::*;

  // ***********************************************
  // declarations
  // ***********************************************
  lpsm_decode_t   dec;
  lpsm_lin_ctrl_t lin_ff;
  lpsm_lin_ctrl_t nxt_lin;
  lpsm_special_t  spec_ff;
  lpsm_special_t  nxt_spec;
  lpsm_tx_state_t tx_state_ff;
  lpsm_tx_state_t nxt_tx_state;
  logic           rb_valid_ff;
  logic           nxt_rb_valid;
  logic [15:0]    rb_data_ff;
  logic [15:0]    nxt_rb_data;
  logic           act_ff;
  logic           nxt_act;
  logic           tx_en_ff;
  logic           nxt_tx_en;
  logic [3:0]     pre_ff;
  logic [3:0]     nxt_pre;
  logic [6:0]     thr_ff;
  logic [6:0]     nxt_thr;
  logic [15:0]    lin_fb;
  logic [15:0]    spec_fb;

  lpsm_frame_decode u_decode (
    .frame_valid (frame_valid),
    .frame_data  (frame_data),
    .dec         (dec)
  );

  // ***********************************************
  // feedback words
  // ***********************************************
  // feedback shows the contents before this frame's write, as the word
  // is shifted out while the new one is still arriving
  assign lin_fb  = {frame_data[15:12], 7'h00, lin_ff.lin_active_enable,
                    lin_ff.lin_slope_select, lin_ff.lin_drive_strength,
                    1'b0, lin_ff.lin_tx_disable};
  assign spec_fb = {frame_data[15:12], 2'h0, spec_ff.sw_dev_mode_init, 2'h0,
                    spec_ff.watchdog_prescale_sel,
                    spec_ff.supply_reset_threshold_sel, 3'h0};

  // ***********************************************
  // register writes and readback
  // ***********************************************
  always_comb begin
    nxt_lin      = lin_ff;
    nxt_spec     = spec_ff;
    nxt_rb_valid = frame_valid;
    nxt_rb_data  = 16'h0000;
    if (dec.hit_lin) begin
      nxt_rb_data = dec.alt_sel ? gp1_feedback : lin_fb; // [R2]
    end else if (dec.hit_spec) begin
      nxt_rb_data = dec.alt_sel ? spec_fb : int_en_feedback; // [R13]
    end
    // reserved positions are not stored, so stray ones read back as zero
    if (dec.wr_lin) begin
      nxt_lin.lin_active_enable  = frame_data.payload[LPSM_LIN_ACT_BIT];   // [R5]
      nxt_lin.lin_slope_select   = frame_data.payload[LPSM_LIN_SLOPE_BIT]; // [R6]
      nxt_lin.lin_drive_strength = frame_data.payload[LPSM_LIN_DRIVE_BIT]; // [R7]
      nxt_lin.lin_tx_disable     = frame_data.payload[LPSM_LIN_TXDIS_BIT]; // [R8]
    end
    if (dec.wr_spec) begin
      nxt_spec.sw_dev_mode_init = frame_data.payload[LPSM_SPEC_SW_DEV_MODE_INIT_BIT]; // [R16]
      nxt_spec.watchdog_prescale_sel =
        frame_data.payload[LPSM_SPEC_WDP_LSB +: 2]; // [R17]
      nxt_spec.supply_reset_threshold_sel =
        frame_data.payload[LPSM_SPEC_THR_LSB +: 2]; // [R18]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lin_ff      <= LPSM_LIN_CTRL_RST;
      spec_ff     <= LPSM_SPECIAL_RST;
      rb_valid_ff <= 1'b0;
      rb_data_ff  <= 16'h0000;
    end else begin
      lin_ff      <= nxt_lin;
      spec_ff     <= nxt_spec;
      rb_valid_ff <= nxt_rb_valid;
      rb_data_ff  <= nxt_rb_data;
    end
  end

  // ***********************************************
  // transmitter shutdown and recovery
  // ***********************************************
  // a failure in the same cycle as a recovery wins, so it is never lost
  always_comb begin
    nxt_tx_state = tx_state_ff;
    unique case (tx_state_ff)
      LPSM_TX_NORMAL: begin
        if (lin_if_fail) begin
          nxt_tx_state = LPSM_TX_FAIL_OFF; // [R9]
        end
      end
      LPSM_TX_FAIL_OFF: begin
        if (lin_if_fail) begin
          nxt_tx_state = LPSM_TX_FAIL_OFF;
        end else if (lin_comm_ok) begin
          nxt_tx_state = LPSM_TX_NORMAL; // [R10]
        end else if (dec.wr_lin && nxt_lin.lin_tx_disable) begin
          nxt_tx_state = LPSM_TX_ARMED; // [R11]
        end
      end
      LPSM_TX_ARMED: begin
        if (lin_if_fail) begin
          nxt_tx_state = LPSM_TX_FAIL_OFF;
        end else if (lin_comm_ok) begin
          nxt_tx_state = LPSM_TX_NORMAL; // [R10]
        end else if (dec.wr_lin && !nxt_lin.lin_tx_disable) begin
          nxt_tx_state = LPSM_TX_NORMAL; // [R11]
        end
      end
      default: begin
        nxt_tx_state = LPSM_TX_FAIL_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_ff <= LPSM_TX_NORMAL;
    end else begin
      tx_state_ff <= nxt_tx_state;
    end
  end

  // ***********************************************
  // registered control outputs
  // ***********************************************
  always_comb begin
    nxt_act   = nxt_lin.lin_active_enable && mode_normal_or_flash; // [R5]
    nxt_tx_en = !nxt_lin.lin_tx_disable && (nxt_tx_state == LPSM_TX_NORMAL); // [R8] [R9]
    unique case (nxt_spec.watchdog_prescale_sel) // [R17]
      2'h0: nxt_pre = LPSM_PRE_X1_0;
      2'h1: nxt_pre = LPSM_PRE_X1_5;
      2'h2: nxt_pre = LPSM_PRE_X2_5;
      2'h3: nxt_pre = LPSM_PRE_X3_5;
    endcase
    unique case (nxt_spec.supply_reset_threshold_sel) // [R18]
      2'h1: nxt_thr = LPSM_THR_PCT_80;
      2'h2: nxt_thr = LPSM_THR_PCT_70;
      2'h0,
      2'h3: nxt_thr = LPSM_THR_PCT_90;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_ff   <= 1'b0;
      tx_en_ff <= 1'b0;
      pre_ff   <= LPSM_PRE_X1_0;
      thr_ff   <= LPSM_THR_PCT_90;
    end else begin
      act_ff   <= nxt_act;
      tx_en_ff <= nxt_tx_en;
      pre_ff   <= nxt_pre;
      thr_ff   <= nxt_thr;
    end
  end

  assign readback_valid             = rb_valid_ff;
  assign readback_data              = rb_data_ff;
  assign lin_active_enable          = act_ff;
  assign lin_slope_select           = lin_ff.lin_slope_select;
  assign lin_drive_strength         = lin_ff.lin_drive_strength;
  assign lin_tx_disable             = lin_ff.lin_tx_disable;
  assign lin_tx_enable              = tx_en_ff;
  assign sw_dev_mode_init           = spec_ff.sw_dev_mode_init;
  assign watchdog_prescale_sel      = spec_ff.watchdog_prescale_sel;
  assign supply_reset_threshold_sel = spec_ff.supply_reset_threshold_sel;
  assign prescale_half_units        = pre_ff;
  assign reset_threshold_pct        = thr_ff;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_LIN_ALT_READ: assert property ( // [R2]
    dec.hit_lin && dec.alt_sel |=> readback_valid && readback_data == $past(gp1_feedback))
    else $error("lin access with select set did not return gp feedback 1");

  AST_LIN_OWN_READ: assert property ( // [R2]
    dec.hit_lin && !dec.alt_sel |=> readback_data[11:5] == 7'h00 &&
      readback_data[0] == $past(lin_tx_disable))
    else $error("lin feedback word wrong");

  AST_LIN_NO_WRITE: assert property ( // [R3]
    dec.hit_lin && frame_data.no_write_flag |=>
      $stable({lin_slope_select, lin_drive_strength, lin_tx_disable}))
    else $error("read-only lin access changed the register");

  AST_LIN_WRITE: assert property ( // [R3]
    dec.wr_lin |=> lin_slope_select == $past(frame_data.payload[LPSM_LIN_SLOPE_BIT]) &&
      lin_drive_strength == $past(frame_data.payload[LPSM_LIN_DRIVE_BIT]))
    else $error("lin write not applied");

  AST_ACTIVE_MODE: assert property ( // [R5]
    lin_active_enable |-> $past(mode_normal_or_flash))
    else $error("lin active outside normal or flash mode");

  AST_TX_GATE: assert property ( // [R8]
    lin_tx_disable |-> !lin_tx_enable)
    else $error("transmitter enabled while disable bit set");

  AST_FAIL_OFF: assert property ( // [R9]
    lin_if_fail && !dec.wr_lin |=> !lin_tx_enable && $stable(lin_tx_disable) ##0
      tx_state_ff != LPSM_TX_NORMAL)
    else $error("interface failure did not shut the transmitter");

  AST_AUTO_RECOVER: assert property ( // [R10]
    tx_state_ff == LPSM_TX_FAIL_OFF && lin_comm_ok && !lin_if_fail && !dec.wr_lin &&
      !lin_tx_disable |=> lin_tx_enable)
    else $error("no automatic recovery on good communication");

  AST_MANUAL_ARM: assert property ( // [R11]
    tx_state_ff == LPSM_TX_FAIL_OFF && !lin_if_fail && !lin_comm_ok && dec.wr_lin &&
      frame_data.payload[LPSM_LIN_TXDIS_BIT] |=>
      tx_state_ff == LPSM_TX_ARMED && !lin_tx_enable)
    else $error("set of disable bit after failure did not arm recovery");

  AST_MANUAL_RECOVER: assert property ( // [R11]
    tx_state_ff == LPSM_TX_ARMED && !lin_if_fail && dec.wr_lin &&
      !frame_data.payload[LPSM_LIN_TXDIS_BIT] |=> lin_tx_enable)
    else $error("set then clear of disable bit did not recover");

  AST_SPEC_READ: assert property ( // [R13]
    dec.hit_spec && !dec.alt_sel |=> readback_data == $past(int_en_feedback))
    else $error("special access did not return interrupt enable feedback");

  AST_SPEC_NO_WRITE: assert property ( // [R14]
    dec.hit_spec && frame_data.no_write_flag |=>
      $stable({sw_dev_mode_init, watchdog_prescale_sel, supply_reset_threshold_sel}))
    else $error("read-only special access changed the register");

  AST_SW_DEV_MODE_INIT: assert property ( // [R16]
    dec.wr_spec |=> sw_dev_mode_init == $past(frame_data.payload[LPSM_SPEC_SW_DEV_MODE_INIT_BIT]))
    else $error("development mode bit not written");

  AST_PRESCALE: assert property ( // [R17]
    watchdog_prescale_sel == 2'h3 |-> prescale_half_units == LPSM_PRE_X3_5)
    else $error("prescale factor decode wrong");

  AST_THRESHOLD: assert property ( // [R18]
    supply_reset_threshold_sel == 2'h2 |-> reset_threshold_pct == LPSM_THR_PCT_70)
    else $error("reset threshold decode wrong");

  AST_UNMAPPED: assert property ( // [R20]
    frame_valid && !dec.hit_lin && !dec.hit_spec |=> readback_valid &&
      readback_data == 16'h0000 && $stable(lin_ff) && $stable(spec_ff))
    else $error("unmapped frame had an effect");

  AST_SPEC_OWN_READ: assert property ( // [R13]
    dec.hit_spec && dec.alt_sel |=> readback_data[11:10] == 2'h0 &&
      readback_data[9] == $past(sw_dev_mode_init) && readback_data[8:7] == 2'h0 &&
      readback_data[6:3] == $past({watchdog_prescale_sel, supply_reset_threshold_sel}) &&
      readback_data[2:0] == 3'h0)
    else $error("special feedback word wrong");

  AST_SPEC_WRITE: assert property ( // [R17] [R18]
    dec.wr_spec |=>
      watchdog_prescale_sel == $past(frame_data.payload[LPSM_SPEC_WDP_LSB +: 2]) &&
      supply_reset_threshold_sel == $past(frame_data.payload[LPSM_SPEC_THR_LSB +: 2]))
    else $error("special mode fields not written");

  AST_TXDIS_WRITE: assert property ( // [R8]
    dec.wr_lin |=> lin_tx_disable == $past(frame_data.payload[LPSM_LIN_TXDIS_BIT]))
    else $error("transmitter disable bit not written");

  AST_ACTIVE_FOLLOW: assert property ( // [R5]
    lin_active_enable == (lin_ff.lin_active_enable && $past(mode_normal_or_flash)))
    else $error("lin active does not follow stored bit and mode");

  AST_THRESHOLD_80: assert property ( // [R18]
    supply_reset_threshold_sel == 2'h1 |-> reset_threshold_pct == LPSM_THR_PCT_80)
    else $error("reset threshold decode wrong for code 01");

  AST_ANSWER_PULSE: assert property ( // [R20]
    readback_valid == $past(frame_valid))
    else $error("answer strobe not one cycle after the frame");

  COV_AUTO_RECOVER: cover property (
    tx_state_ff == LPSM_TX_FAIL_OFF ##1 tx_state_ff == LPSM_TX_NORMAL);
  COV_MANUAL_RECOVER: cover property (
    tx_state_ff == LPSM_TX_ARMED ##1 tx_state_ff == LPSM_TX_NORMAL);
  COV_SPEC_WRITE: cover property (dec.wr_spec && frame_data.payload[LPSM_SPEC_SW_DEV_MODE_INIT_BIT]);
  COV_GP1_READ: cover property (dec.hit_lin && dec.alt_sel);
  COV_FAIL_WINS: cover property (
    tx_state_ff == LPSM_TX_FAIL_OFF && lin_if_fail && lin_comm_ok);

endmodule : lpsm_regs
